// ==== src/ppsm_phy_end.sv ====
// PHY-side power-state manager: state machine, break-link timer, pin sync.
// Assumes PHY status inputs are on i_clk; the two pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module ppsm_phy_end
    import ppsm_pkg::*;
#(
    parameter int C2AN_CYCLES = C2AN_MIN_CYC
)(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // Interconnect
    ppsm_if.dev             bus,
    // PHY status
    input  wire logic       i_cable_present,
    input  wire logic       i_an_link_ok,
    input  wire logic       i_traffic,
    input  wire logic       i_lpi_en,
    input  wire logic       i_partner_lpi,
    input  wire logic       i_pd_mode,
    input  wire logic       i_pcie_en,
    // Power controls
    output logic [2:0]      o_state,
    output logic            o_low_current,
    output logic            o_lcd_reset,
    output logic            o_energy_detect,
    output logic            o_advertise,
    output logic            o_phy_pd,
    output logic            o_clk_gate,
    output logic            o_pcie_ei,
    output logic            o_pcie_pd,
    output logic            o_rx_off,
    output logic            o_tx_lpi
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [1:0]  sy1_r;
    logic [1:0]  sy2_r;
    logic [1:0]  sy3_r;
    logic [1:0]  lvl_r;
    wire  [1:0]  lvl_nxt = ((sy2_r ~^ sy3_r) & sy3_r) | ((sy2_r ^ sy3_r) & lvl_r);

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sy1_r <= PIN_RESET;
            sy2_r <= PIN_RESET;
            sy3_r <= PIN_RESET;
            lvl_r <= PIN_RESET;
        end
        else
        begin
            sy1_r <= {bus.port_power_good_n, bus.port_disable_n};
            sy2_r <= sy1_r;
            sy3_r <= sy2_r;
            lvl_r <= lvl_nxt;
        end
    end

    // ************************************************************
    // Decode
    // ************************************************************
    ppsm_state_e state_r;
    ppsm_state_e state_nxt;
    logic        shut_msg_r;
    logic        pd_bit_r;
    logic        advertise_r;
    logic [31:0] c2an_cnt_r;
    logic        rx_off_r;

    wire msg_shut  = bus.msg_valid && (bus.msg_code == MSG_SHUTDOWN);
    wire msg_wake  = bus.msg_valid && (bus.msg_code == MSG_WAKE);
    wire msg_cfg   = bus.msg_valid && (bus.msg_code == MSG_CFG_DONE);
    wire msg_lpi1  = bus.msg_valid && (bus.msg_code == MSG_TXLPI_ON);
    wire msg_lpi0  = bus.msg_valid && (bus.msg_code == MSG_TXLPI_OFF);
    wire pin_pd    = ~lvl_r[0];
    // Stay-active mode ignores shutdown commands altogether
    wire cmd_pd    = (i_pd_mode == PD_MODE_DOWN) && (~lvl_r[1] || shut_msg_r);
    wire in_link   = (state_r == ST_ACTIVE) || (state_r == ST_IDLE);
    wire nxt_link  = (state_nxt == ST_ACTIVE) || (state_nxt == ST_IDLE);
    wire nxt_down  = (state_nxt == ST_SHUTDOWN) || (state_nxt == ST_IEEE_PD);
    wire link_st   = i_traffic;
    wire timer_end = (c2an_cnt_r == 32'(C2AN_CYCLES - 1));
    wire rx_lpi    = i_lpi_en && i_partner_lpi && nxt_link;
    wire can_down  = (state_r != ST_PWR_UP) && (state_r != ST_SHUTDOWN);

    // ************************************************************
    // State machine
    // ************************************************************
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_PWR_UP:     state_nxt = ST_WAIT_CFG;
            ST_WAIT_CFG:
                if (msg_cfg)
                    state_nxt = i_cable_present ? ST_NEGOTIATE : ST_CABLE_DISC;
            ST_NEGOTIATE:
                if (!i_cable_present)
                    state_nxt = ST_CABLE_DISC;
                else if (advertise_r && i_an_link_ok)
                    state_nxt = link_st ? ST_ACTIVE : ST_IDLE;
            ST_ACTIVE, ST_IDLE:
                if (!i_cable_present)
                    state_nxt = ST_CABLE_DISC;
                else if (!i_an_link_ok)
                    state_nxt = ST_NEGOTIATE;
                else
                    state_nxt = link_st ? ST_ACTIVE : ST_IDLE;
            ST_CABLE_DISC:
                if (i_cable_present)
                    state_nxt = ST_NEGOTIATE;
            ST_IEEE_PD:
                if (!pd_bit_r)
                    state_nxt = ST_NEGOTIATE;
            ST_SHUTDOWN:
                if (!pin_pd && !cmd_pd)
                    state_nxt = ST_WAIT_CFG;
        endcase
        if (can_down && (pin_pd || cmd_pd))
            state_nxt = ST_SHUTDOWN;
        else if (can_down && pd_bit_r && (state_r != ST_WAIT_CFG))
            state_nxt = ST_IEEE_PD;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_r    <= ST_PWR_UP;
            shut_msg_r <= 1'b0;
            pd_bit_r   <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            if (msg_shut && (i_pd_mode == PD_MODE_DOWN))
                shut_msg_r <= 1'b1;
            else if (msg_wake)
                shut_msg_r <= 1'b0;
            // A reset-complete cycle returns the control register to default
            if (state_nxt == ST_WAIT_CFG)
                pd_bit_r <= PHY_CTRL_RESET[PHY_CTRL_PD_BIT];
            else if (bus.mdio_wr)
                pd_bit_r <= bus.mdio_data[PHY_CTRL_PD_BIT];
        end
    end

    // ************************************************************
    // Break-link timer
    // ************************************************************
    // Restarts on entry into negotiation except from active or idle, so a bouncing cable waits anew
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            c2an_cnt_r  <= 32'h0000_0000;
            advertise_r <= 1'b0;
        end
        else if (state_r == ST_NEGOTIATE)
        begin
            if (!advertise_r)
                c2an_cnt_r <= c2an_cnt_r + 32'h0000_0001;
            if (timer_end)
                advertise_r <= 1'b1;
        end
        else if (!in_link)
        begin
            c2an_cnt_r  <= 32'h0000_0000;
            advertise_r <= 1'b0;
        end
    end

    // ************************************************************
    // Power controls and link reports
    // ************************************************************
    logic low_cur_r;
    logic lcd_rst_r;
    logic edet_r;
    logic phy_pd_r;
    logic pcie_ei_r;
    logic pcie_pd_r;
    logic tx_lpi_r;
    logic link_up_r;
    logic unplug_r;
    logic ind_v_r;
    logic [1:0] ind_c_r;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            low_cur_r <= 1'b1;
            lcd_rst_r <= 1'b0;
            edet_r    <= 1'b0;
            phy_pd_r  <= 1'b0;
            pcie_ei_r <= 1'b0;
            pcie_pd_r <= 1'b0;
            rx_off_r  <= 1'b0;
            tx_lpi_r  <= 1'b0;
            link_up_r <= 1'b0;
            unplug_r  <= 1'b0;
            ind_v_r   <= 1'b0;
            ind_c_r   <= IND_NONE;
        end
        else
        begin
            low_cur_r <= (state_nxt == ST_PWR_UP);
            lcd_rst_r <= (state_r == ST_PWR_UP);
            edet_r    <= (state_nxt == ST_CABLE_DISC);
            pcie_pd_r <= (state_nxt == ST_CABLE_DISC);
            unplug_r  <= (state_nxt == ST_CABLE_DISC);
            link_up_r <= nxt_link;
            phy_pd_r  <= nxt_down;
            // In shutdown with i_pcie_en set, PCIe idles one cycle after the PHY is already down
            pcie_ei_r <= phy_pd_r && (state_r == ST_SHUTDOWN) && i_pcie_en;
            rx_off_r  <= rx_lpi;
            if (msg_lpi1 && i_lpi_en && nxt_link)
                tx_lpi_r <= 1'b1;
            else if (msg_lpi0 || !nxt_link)
                tx_lpi_r <= 1'b0;
            ind_v_r <= 1'b0;
            ind_c_r <= IND_NONE;
            if ((state_nxt == ST_WAIT_CFG) && (state_r != ST_WAIT_CFG))
            begin
                ind_v_r <= 1'b1;
                ind_c_r <= IND_RESET_DONE;
            end
            else if (rx_lpi != rx_off_r)
            begin
                ind_v_r <= 1'b1;
                ind_c_r <= rx_lpi ? IND_RXLPI_ON : IND_RXLPI_OFF;
            end
        end
    end

    assign o_state         = state_r;
    assign o_low_current   = low_cur_r;
    assign o_lcd_reset     = lcd_rst_r;
    assign o_energy_detect = edet_r;
    assign o_advertise     = advertise_r;
    assign o_phy_pd        = phy_pd_r;
    assign o_clk_gate      = pcie_ei_r;
    assign o_pcie_ei       = pcie_ei_r;
    assign o_pcie_pd       = pcie_pd_r;
    assign o_rx_off        = rx_off_r;
    assign o_tx_lpi        = tx_lpi_r;
    assign bus.link_up     = link_up_r;
    assign bus.unplugged   = unplug_r;
    assign bus.ind_valid   = ind_v_r;
    assign bus.ind_code    = ind_c_r;

endmodule : ppsm_phy_end
`default_nettype wire

// ==== src/ppsm_pkg.sv ====
// Shared constants for the PHY power-state manager and its controller end.
// Assumes both ends run on the same 125 MHz clock.
package ppsm_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_MHZ          = 125;
    localparam int C2AN_MIN_MS      = 1200;
    localparam int C2AN_MAX_MS      = 1300;
    // Least time rounds up; 1.2 s is a whole number of cycles
    localparam int C2AN_MIN_CYC     = C2AN_MIN_MS * CLK_MHZ * 1000;
    localparam int C2AN_MAX_CYC     = C2AN_MAX_MS * CLK_MHZ * 1000;
    localparam int CFG_LIMIT_MS     = 500;
    localparam int CFG_LIMIT_CYC    = CFG_LIMIT_MS * CLK_MHZ * 1000;
    localparam int CFG_DELAY_CYC    = 16;

    // ************************************************************
    // Register fields and codes
    // ************************************************************
    localparam int          PHY_CTRL_PD_BIT = 11;
    localparam logic [15:0] PHY_CTRL_RESET  = 16'h0000;
    localparam logic        PD_MODE_STAY    = 1'b0;
    localparam logic        PD_MODE_DOWN    = 1'b1;
    localparam logic [1:0]  PIN_RESET       = 2'h3;

    localparam logic [2:0]  MSG_NONE        = 3'h0;
    localparam logic [2:0]  MSG_SHUTDOWN    = 3'h1;
    localparam logic [2:0]  MSG_WAKE        = 3'h2;
    localparam logic [2:0]  MSG_TXLPI_ON    = 3'h3;
    localparam logic [2:0]  MSG_TXLPI_OFF   = 3'h4;
    localparam logic [2:0]  MSG_CFG_DONE    = 3'h5;

    localparam logic [1:0]  IND_NONE        = 2'h0;
    localparam logic [1:0]  IND_RESET_DONE  = 2'h1;
    localparam logic [1:0]  IND_RXLPI_ON    = 2'h2;
    localparam logic [1:0]  IND_RXLPI_OFF   = 2'h3;

    typedef enum logic [2:0] {
        ST_PWR_UP     = 3'h0,
        ST_WAIT_CFG   = 3'h1,
        ST_NEGOTIATE  = 3'h2,
        ST_ACTIVE     = 3'h3,
        ST_IDLE       = 3'h4,
        ST_CABLE_DISC = 3'h5,
        ST_IEEE_PD    = 3'h6,
        ST_SHUTDOWN   = 3'h7
    } ppsm_state_e;

endpackage : ppsm_pkg

// ==== src/ppsm_if.sv ====
// Interconnect between the PHY end and the LAN controller end.
// Both ends share one clock; the two pins are resolved as plain wires.
`timescale 1ns/1ps
`default_nettype none
interface ppsm_if;
    logic        msg_valid;
    logic [2:0]  msg_code;
    logic        mdio_wr;
    logic [15:0] mdio_data;
    logic        port_disable_n;
    logic        port_power_good_n;
    logic        link_up;
    logic        unplugged;
    logic        ind_valid;
    logic [1:0]  ind_code;

    modport dev (
        input  msg_valid, msg_code, mdio_wr, mdio_data,
        input  port_disable_n, port_power_good_n,
        output link_up, unplugged, ind_valid, ind_code
    );
    modport ctl (
        output msg_valid, msg_code, mdio_wr, mdio_data,
        output port_disable_n, port_power_good_n,
        input  link_up, unplugged, ind_valid, ind_code
    );
endinterface : ppsm_if
`default_nettype wire

// ==== src/ppsm_ctl_end.sv ====
// LAN-controller end: drives the two pins, sends in-band messages, configures.
// Assumes the PHY end shares i_clk; user requests are on i_clk.
`timescale 1ns/1ps
`default_nettype none
module ppsm_ctl_end
    import ppsm_pkg::*;
#(
    parameter int CFG_DELAY = CFG_DELAY_CYC
)(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // Interconnect
    ppsm_if.ctl             bus,
    // User requests
    input  wire logic       i_disable,
    input  wire logic       i_pin_usable,
    input  wire logic       i_power_good,
    input  wire logic       i_shutdown_req,
    input  wire logic       i_wake_req,
    input  wire logic       i_pd_bit_req,
    input  wire logic       i_tx_lpi_req,
    // Status
    output logic            o_configured,
    output logic            o_link_up,
    output logic            o_unplugged,
    output logic            o_rx_lpi
);

    // ************************************************************
    // Decode
    // ************************************************************
    // Delay stays well under the configuration limit after reset-done
    localparam int CFG_CNT = (CFG_DELAY < CFG_LIMIT_CYC) ? CFG_DELAY : 1;

    logic        dis_r;
    logic        shut_pend_r;
    logic        wake_pend_r;
    logic        cfg_busy_r;
    logic        cfg_r;
    logic [31:0] cfg_cnt_r;
    logic        pd_sent_r;
    logic        lpi_sent_r;

    wire rst_done  = bus.ind_valid && (bus.ind_code == IND_RESET_DONE);
    wire dis_rise  = i_disable && !dis_r;
    wire dis_fall  = !i_disable && dis_r;
    wire shut_in   = i_shutdown_req || (dis_rise && !i_pin_usable);
    wire wake_in   = i_wake_req || (dis_fall && !i_pin_usable);
    wire cfg_fire  = cfg_busy_r && (cfg_cnt_r == 32'(CFG_CNT - 1));
    wire pd_due    = cfg_r && (i_pd_bit_req != pd_sent_r);
    wire lpi_due   = cfg_r && bus.link_up && (i_tx_lpi_req != lpi_sent_r);
    wire send_shut = !cfg_fire && shut_pend_r;
    wire send_wake = !cfg_fire && !shut_pend_r && wake_pend_r;
    wire send_lpi  = !cfg_fire && !shut_pend_r && !wake_pend_r && lpi_due;

    // ************************************************************
    // Configuration and messages
    // ************************************************************
    logic        msg_v_r;
    logic [2:0]  msg_c_r;
    logic        mdio_wr_r;
    logic [15:0] mdio_d_r;
    logic        dis_n_r;
    logic        pg_n_r;
    logic        rx_lpi_r;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            dis_r       <= 1'b0;
            shut_pend_r <= 1'b0;
            wake_pend_r <= 1'b0;
            cfg_busy_r  <= 1'b0;
            cfg_r       <= 1'b0;
            cfg_cnt_r   <= 32'h0000_0000;
            pd_sent_r   <= 1'b0;
            lpi_sent_r  <= 1'b0;
            msg_v_r     <= 1'b0;
            msg_c_r     <= MSG_NONE;
            mdio_wr_r   <= 1'b0;
            mdio_d_r    <= PHY_CTRL_RESET;
            dis_n_r     <= 1'b1;
            pg_n_r      <= 1'b1;
            rx_lpi_r    <= 1'b0;
        end
        else
        begin
            dis_r   <= i_disable;
            dis_n_r <= !(i_disable && i_pin_usable);
            // Pin is low to shut down, whatever its name suggests
            pg_n_r  <= i_power_good;
            // A new request in the cycle of sending wins over the clear
            shut_pend_r <= shut_in || (shut_pend_r && !send_shut);
            wake_pend_r <= wake_in || (wake_pend_r && !send_wake);
            if (rst_done)
            begin
                cfg_busy_r <= 1'b1;
                cfg_r      <= 1'b0;
                cfg_cnt_r  <= 32'h0000_0000;
                pd_sent_r  <= PHY_CTRL_RESET[PHY_CTRL_PD_BIT];
                lpi_sent_r <= 1'b0;
            end
            else if (cfg_fire)
            begin
                cfg_busy_r <= 1'b0;
                cfg_r      <= 1'b1;
            end
            else if (cfg_busy_r)
                cfg_cnt_r <= cfg_cnt_r + 32'h0000_0001;
            msg_v_r <= cfg_fire || send_shut || send_wake || send_lpi;
            if (cfg_fire)
                msg_c_r <= MSG_CFG_DONE;
            else if (send_shut)
                msg_c_r <= MSG_SHUTDOWN;
            else if (send_wake)
                msg_c_r <= MSG_WAKE;
            else if (send_lpi)
                msg_c_r <= i_tx_lpi_req ? MSG_TXLPI_ON : MSG_TXLPI_OFF;
            else
                msg_c_r <= MSG_NONE;
            if (send_lpi)
                lpi_sent_r <= i_tx_lpi_req;
            mdio_wr_r <= pd_due && !rst_done;
            if (pd_due && !rst_done)
            begin
                mdio_d_r                  <= PHY_CTRL_RESET;
                mdio_d_r[PHY_CTRL_PD_BIT] <= i_pd_bit_req;
                pd_sent_r                 <= i_pd_bit_req;
            end
            if (bus.ind_valid && (bus.ind_code == IND_RXLPI_ON))
                rx_lpi_r <= 1'b1;
            else if ((bus.ind_valid && (bus.ind_code == IND_RXLPI_OFF)) || !bus.link_up)
                rx_lpi_r <= 1'b0;
        end
    end

    logic link_r;
    logic unpl_r;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            link_r <= 1'b0;
            unpl_r <= 1'b0;
        end
        else
        begin
            link_r <= bus.link_up;
            unpl_r <= bus.unplugged;
        end
    end

    assign bus.msg_valid         = msg_v_r;
    assign bus.msg_code          = msg_c_r;
    assign bus.mdio_wr           = mdio_wr_r;
    assign bus.mdio_data         = mdio_d_r;
    assign bus.port_disable_n    = dis_n_r;
    assign bus.port_power_good_n = pg_n_r;
    assign o_configured          = cfg_r;
    assign o_link_up             = link_r;
    assign o_unplugged           = unpl_r;
    assign o_rx_lpi              = rx_lpi_r;

endmodule : ppsm_ctl_end
`default_nettype wire

// ==== test/ppsm_asserts.sv ====
// Checker on the interconnect between the PHY end and the controller end.
// Assumes one shared clock and the active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module ppsm_asserts
    import ppsm_pkg::*;
(
    // Clock and reset
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    // Interconnect
    input wire logic        msg_valid,
    input wire logic [2:0]  msg_code,
    input wire logic        mdio_wr,
    input wire logic [15:0] mdio_data,
    input wire logic        port_disable_n,
    input wire logic        port_power_good_n,
    input wire logic        link_up,
    input wire logic        unplugged,
    input wire logic        ind_valid,
    input wire logic [1:0]  ind_code
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    logic cfg_seen_r;
    wire  cfg_msg = msg_valid && (msg_code == MSG_CFG_DONE);
    wire  rst_ind = ind_valid && (ind_code == IND_RESET_DONE);
    // Every reset-done starts a fresh configuration cycle
    always_ff @(posedge i_clk or negedge i_rst_n)
        if (!i_rst_n)
            cfg_seen_r <= 1'b0;
        else if (rst_ind)
            cfg_seen_r <= 1'b0;
        else if (cfg_msg)
            cfg_seen_r <= 1'b1;
    unplug_no_link_a: assert property (unplugged |-> !link_up)
        else $error("link up while unplugged");
    energy_wait_a: assert property ($fell(unplugged) |-> !link_up [*2])
        else $error("link up without break-link wait");
    pd_bit_down_a: assert property (mdio_wr && mdio_data[PHY_CTRL_PD_BIT] |-> ##[1:2] !link_up)
        else $error("link kept after power-down bit");
    mdio_after_cfg_a: assert property (mdio_wr |-> cfg_seen_r)
        else $error("control write before configuration");
    disable_fall_a: assert property ($fell(port_disable_n) |-> ##[1:8] !link_up)
        else $error("link kept after disable fall");
    disable_hold_a: assert property (!port_disable_n [*8] |-> !link_up)
        else $error("link up while disabled");
    reset_done_a: assert property ($rose(i_rst_n) |-> ##[1:2] rst_ind)
        else $error("no reset-done after reset");
    cfg_follow_a: assert property (rst_ind |-> ##[1:40] cfg_msg)
        else $error("configuration late after reset-done");
endmodule : ppsm_asserts
`default_nettype wire

// ==== test/phy_power_state_manager_bench.sv ====
// Bench joining both ends through the interface, with the checker beside it.
// Assumes a short break-link count so that runs stay brief.
`timescale 1ns/1ps
`default_nettype none
module phy_power_state_manager_bench
    import ppsm_pkg::*;
;
    localparam int C2AN = 20;
    logic       clk, rst_n, cable, an_ok, traffic, lpi_en, p_lpi, pd_mode, pcie_en;
    logic       dis, pin_ok, pgood, shut, wake, pd_bit, tx_req;
    logic [2:0] state, prev;
    logic       phy_pd, pcie_ei, pcie_pd, energy, rx_off, tx_lpi, unpl, rx_lpi;
    logic       low_cur, lcd_rst, adv, clk_gate, cfgd, ctl_link;
    logic [2:0] note_q[$];
    logic [31:0] lfsr;
    int         miscompares, total_checks;
    ppsm_if bus ();
    ppsm_phy_end #(.C2AN_CYCLES(C2AN)) ppsm_phy_end_i (
        .i_clk(clk), .i_rst_n(rst_n), .bus(bus), .i_cable_present(cable),
        .i_an_link_ok(an_ok), .i_traffic(traffic), .i_lpi_en(lpi_en),
        .i_partner_lpi(p_lpi), .i_pd_mode(pd_mode), .i_pcie_en(pcie_en),
        .o_state(state), .o_low_current(low_cur), .o_lcd_reset(lcd_rst),
        .o_energy_detect(energy), .o_advertise(adv), .o_phy_pd(phy_pd),
        .o_clk_gate(clk_gate), .o_pcie_ei(pcie_ei),
        .o_pcie_pd(pcie_pd), .o_rx_off(rx_off), .o_tx_lpi(tx_lpi));
    ppsm_ctl_end ppsm_ctl_end_i (
        .i_clk(clk), .i_rst_n(rst_n), .bus(bus), .i_disable(dis), .i_pin_usable(pin_ok),
        .i_power_good(pgood), .i_shutdown_req(shut), .i_wake_req(wake),
        .i_pd_bit_req(pd_bit), .i_tx_lpi_req(tx_req), .o_configured(cfgd),
        .o_link_up(ctl_link), .o_unplugged(unpl), .o_rx_lpi(rx_lpi));
    ppsm_asserts ppsm_asserts_i (
        .i_clk(clk), .i_rst_n(rst_n), .msg_valid(bus.msg_valid), .msg_code(bus.msg_code),
        .mdio_wr(bus.mdio_wr), .mdio_data(bus.mdio_data), .link_up(bus.link_up),
        .port_disable_n(bus.port_disable_n), .port_power_good_n(bus.port_power_good_n),
        .unplugged(bus.unplugged), .ind_valid(bus.ind_valid), .ind_code(bus.ind_code));
    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %0h want %0h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic go(input logic [2:0] s);
        int n;
        n = 0;
        note_q.push_back(s);
        while (state !== s && n < 400)
        begin
            @(posedge clk);
            n++;
        end
        #1;
        check(state, s);
    endtask : go
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next
    // Traffic is only changed in negotiation, where it cannot move the state
    task automatic relink();
        lfsr = lfsr_next(lfsr);
        traffic = lfsr[0];
        go(traffic ? ST_ACTIVE : ST_IDLE);
    endtask : relink
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict
    // ************************************************************
    // Clock, watchdog and state monitor
    // ************************************************************
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial
    begin
        #(8 * 20000);
        miscompares++;
        print_verdict();
    end
    // Every state change must match the oldest note; none left means a stray change
    always @(posedge clk)
    begin
        prev <= state;
        if (rst_n && state !== prev)
            check(state, note_q.size() > 0 ? note_q.pop_front() : 3'hX);
    end
    // ************************************************************
    // Scenarios
    // ************************************************************
    initial
    begin
        {rst_n, lpi_en, p_lpi, dis, shut, wake, pd_bit, tx_req} = 8'h00;
        {cable, an_ok, traffic, pd_mode, pcie_en, pin_ok, pgood} = 7'h7F;
        lfsr = 32'hD4B564EF;
        miscompares = 0;
        total_checks = 0;
        note_q.push_back(ST_WAIT_CFG);
        tick(3);
        check({low_cur, lcd_rst, adv}, 3'h4);
        rst_n = 1'b1;
        tick(1);
        check({low_cur, lcd_rst, adv}, 3'h2);
        go(ST_NEGOTIATE);
        check({low_cur, lcd_rst, adv}, 3'h0);
        relink();
        check({cfgd, ctl_link, adv}, 3'h7);
        $display("power-up test done");
        cable = 1'b0;
        go(ST_CABLE_DISC);
        tick(2);
        check({unpl, energy, pcie_pd}, 3'h7);
        cable = 1'b1;
        go(ST_NEGOTIATE);
        tick(2);
        check({unpl, bus.link_up, phy_pd}, 3'h0);
        relink();
        $display("cable test done");
        pd_bit = 1'b1;
        go(ST_IEEE_PD);
        tick(2);
        check({phy_pd, pcie_ei, bus.link_up}, 3'h4);
        pd_bit = 1'b0;
        go(ST_NEGOTIATE);
        relink();
        $display("control power-down test done");
        // Second pass uses the in-band path with the PCIe link switched off
        for (int u = 1; u >= 0; u--)
        begin
            pin_ok = u[0];
            pcie_en = u[0];
            dis = 1'b1;
            go(ST_SHUTDOWN);
            tick(3);
            check({phy_pd, pcie_ei, clk_gate, bus.link_up}, u ? 4'hE : 4'h8);
            dis = 1'b0;
            go(ST_WAIT_CFG);
            go(ST_NEGOTIATE);
            relink();
        end
        pcie_en = 1'b1;
        $display("disable test done");
        pd_mode = 1'b0;
        shut = 1'b1;
        pgood = 1'b0;
        tick(1);
        shut = 1'b0;
        tick(10);
        check(state, traffic ? ST_ACTIVE : ST_IDLE);
        pd_mode = 1'b1;
        go(ST_SHUTDOWN);
        // An in-band shutdown keeps the device down after the pin recovers
        shut = 1'b1;
        tick(1);
        shut = 1'b0;
        tick(4);
        pgood = 1'b1;
        tick(8);
        check(state, ST_SHUTDOWN);
        wake = 1'b1;
        tick(1);
        wake = 1'b0;
        go(ST_WAIT_CFG);
        go(ST_NEGOTIATE);
        relink();
        $display("shutdown test done");
        {lpi_en, p_lpi, tx_req} = 3'h7;
        tick(6);
        check({rx_off, rx_lpi, tx_lpi}, 3'h7);
        {p_lpi, tx_req} = 2'h0;
        tick(6);
        check({rx_off, rx_lpi, tx_lpi}, 3'h0);
        $display("low-power idle test done");
        print_verdict();
    end
endmodule : phy_power_state_manager_bench
`default_nettype wire
